// ===== core/ppsio_edge.sv
// edge detector for the strobe input with selectable active edge
`timescale 1ns/1ps
module ppsio_edge (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // strobe input and edge choice (1 = rising)
  input wire logic strobe_in_line,
  input wire logic strobe_in_edge_select,
  // one-cycle pulse on the chosen edge
  output logic active_edge
);

  logic prev_level; // level seen one clock earlier

  // input is taken as synchronous, so one stage is enough to see an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_level <= strobe_in_line; // track the pin: no false edge at exit
    end else begin
      prev_level <= strobe_in_line;
    end
  end

  // pick rising or falling edge
  always_comb begin
    if (strobe_in_edge_select) begin
      active_edge = strobe_in_line && !prev_level;
    end else begin
      active_edge = !strobe_in_line && prev_level;
    end
  end

endmodule

// ===== core/ppsio_top.sv
// parallel port block with simple strobed mode behind an axi4-lite slave
//
// Notes on behaviour
// - direction bits; reset makes all lines inputs
// - output line reads return driver input
// - input lines float; writes only load latch
// - port a lines 0-2 input, writes ignored
// - port a lines 3-6 output, read driver
// - port a line 7 direction from control bit
// - port b output only, reads driver input
// - port e eight inputs, writes ignored
// - handshake select clear gives simple strobed mode
// - strobe output polarity follows invert bit
// - port c readable direct and latched
// - edge select picks rising or falling strobe
// - active edge captures port c, sets flag
// - capture on every edge, overwriting old data
// - flag plus enable requests interrupt
// - status read then latched read clears flag
// - strobe pins replace bus control pins
// - port b write pulses strobe two cycles
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module ppsio_top import ppsio_pkg::*; #(
  parameter int PORT_W = 8,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port a pins
  input wire logic [PORT_W-1:0] first_port_in,
  output logic [PORT_W-1:0] first_port_out,
  output logic [PORT_W-1:0] first_port_oe,
  // port b pins, output only
  output logic [PORT_W-1:0] second_port_out,
  // port c pins
  input wire logic [PORT_W-1:0] third_port_in,
  output logic [PORT_W-1:0] third_port_out,
  output logic [PORT_W-1:0] third_port_oe,
  // port d pins
  input wire logic [PORT_W-1:0] fourth_port_in,
  output logic [PORT_W-1:0] fourth_port_out,
  output logic [PORT_W-1:0] fourth_port_oe,
  // port e pins, input only
  input wire logic [PORT_W-1:0] fifth_port_in,
  // strobe lines and interrupt request
  input wire logic strobe_in_line,
  output logic strobe_out_line,
  output logic strobe_in_irq
);

  // the fixed port a line map only makes sense for eight lines
  if (PORT_W != 8) begin : g_bad_width
    $error("ppsio_top: PORT_W must be 8");
  end
  if (ADDR_W < 6) begin : g_bad_addr
    $error("ppsio_top: ADDR_W must be at least 6");
  end

  // software visible state
  logic [PORT_W-1:0] port_a_latch; // port a output latch
  logic [PORT_W-1:0] port_b_latch; // port b output latch
  logic [PORT_W-1:0] port_c_latch; // port c output latch
  logic [PORT_W-1:0] port_c_dir; // 1 = output
  logic [PORT_W-1:0] port_d_latch; // port d output latch
  logic [PORT_W-1:0] port_d_dir; // 1 = output
  logic [PORT_W-1:0] third_port_latched_reg; // strobe capture
  logic first_port_line7_dir; // port a line 7 direction
  logic strobe_in_flag; // set by active strobe edge
  logic strobe_in_irq_enable; // lets the flag request interrupt
  logic handshake_select; // 0 = simple strobed mode
  logic strobe_in_edge_select; // 1 = rising edge active
  logic strobe_out_invert; // 1 = strobe pulse active high
  logic flag_clear_armed; // status read saw the flag set

  // bus side state
  logic aw_got; // write address held
  logic w_got; // write data held
  logic [ADDR_W-1:0] aw_addr; // held write address
  logic [7:0] w_byte; // held low data byte
  logic w_lane0; // low byte lane was enabled
  logic [1:0] strobe_cnt; // strobe output cycles left

  // decoded events
  logic active_edge; // chosen edge on the strobe input
  logic wr_fire; // both write halves present, no response pending
  logic rd_fire; // read address taken this cycle
  logic [7:0] wr_off; // write offset
  logic [7:0] rd_off; // read offset
  logic wr_en; // write with low lane enabled
  logic [7:0] rd_byte; // read mux result
  logic rd_hit; // read address maps a register
  logic wr_hit; // write address maps a register
  logic [PORT_W-1:0] pins_c_view; // port c data register view
  logic [PORT_W-1:0] pins_d_view; // port d data register view
  logic [PORT_W-1:0] port_a_view; // port a data register view
  logic [7:0] pio_ctrl_view; // control register view
  logic strobed_mode; // simple strobed mode active

  assign strobed_mode = !handshake_select;
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_off = 8'(aw_addr);
  assign rd_off = 8'(s_axi_araddr);
  assign wr_en = wr_fire && w_lane0;

  // edge detector on the strobe input pin
  ppsio_edge u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .strobe_in_line(strobe_in_line),
    .strobe_in_edge_select(strobe_in_edge_select),
    .active_edge(active_edge)
  );

  // write address channel: take once, hold until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_got <= 1'b0;
    end else if (!aw_got && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel: same shape, either order against the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_got <= 1'b0;
    end else if (!w_got && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write decode: which offsets are mapped at all
  always_comb begin
    case (wr_off)
      PPSIO_OFF_PORT_A, PPSIO_OFF_PORT_B, PPSIO_OFF_PINS_C,
      PPSIO_OFF_LATCH_C, PPSIO_OFF_DIR_C, PPSIO_OFF_PORT_D,
      PPSIO_OFF_DIR_D, PPSIO_OFF_PORT_E, PPSIO_OFF_PIO_CTRL,
      PPSIO_OFF_PACC_CTRL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write response: unmapped offsets answer slverr and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PPSIO_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? PPSIO_RESP_OKAY : PPSIO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // port a latch: lines 0..2 are input only, so writes there are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_latch <= PPSIO_RST_PORT;
    end else if (wr_en && wr_off == PPSIO_OFF_PORT_A) begin
      port_a_latch <= w_byte & PPSIO_PA_WR_MASK;
    end
  end

  // port b latch; port e has no latch, its writes vanish
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_b_latch <= PPSIO_RST_PORT;
    end else if (wr_en && wr_off == PPSIO_OFF_PORT_B) begin
      port_b_latch <= w_byte;
    end
  end

  // port c latch: both the direct and latched addresses write it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_c_latch <= PPSIO_RST_PORT;
    end else if (wr_en && (wr_off == PPSIO_OFF_PINS_C ||
                           wr_off == PPSIO_OFF_LATCH_C)) begin
      port_c_latch <= w_byte;
    end
  end

  // port d latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_d_latch <= PPSIO_RST_PORT;
    end else if (wr_en && wr_off == PPSIO_OFF_PORT_D) begin
      port_d_latch <= w_byte;
    end
  end

  // direction registers: reset leaves every general line an input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_c_dir <= PPSIO_RST_DIR;
      port_d_dir <= PPSIO_RST_DIR;
      first_port_line7_dir <= 1'b0;
    end else if (wr_en) begin
      if (wr_off == PPSIO_OFF_DIR_C) begin
        port_c_dir <= w_byte;
      end
      if (wr_off == PPSIO_OFF_DIR_D) begin
        port_d_dir <= w_byte;
      end
      if (wr_off == PPSIO_OFF_PACC_CTRL) begin
        first_port_line7_dir <= w_byte[PPSIO_BIT_LINE7_DIR];
      end
    end
  end

  // control bits; the flag position is read only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_in_irq_enable <= 1'b0;
      handshake_select <= 1'b0;
      strobe_in_edge_select <= PPSIO_RST_EDGE_SEL;
      strobe_out_invert <= PPSIO_RST_INVERT;
    end else if (wr_en && wr_off == PPSIO_OFF_PIO_CTRL) begin
      strobe_in_irq_enable <= w_byte[PPSIO_BIT_IRQ_EN];
      handshake_select <= w_byte[PPSIO_BIT_HANDSHAKE];
      strobe_in_edge_select <= w_byte[PPSIO_BIT_EDGE_SEL];
      strobe_out_invert <= w_byte[PPSIO_BIT_INVERT];
    end
  end

  // capture port c on every active edge in simple strobed mode, even with the flag still set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      third_port_latched_reg <= PPSIO_RST_PORT;
    end else if (active_edge && strobed_mode) begin
      third_port_latched_reg <= third_port_in;
    end
  end

  // flag: an edge in the clearing cycle wins so no strobe is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_in_flag <= 1'b0;
    end else if (active_edge && strobed_mode) begin
      strobe_in_flag <= 1'b1;
    end else if (rd_fire && rd_off == PPSIO_OFF_LATCH_C &&
                 flag_clear_armed) begin
      strobe_in_flag <= 1'b0;
    end
  end

  // clear arming: set by a status read that returns the flag set,
  // dropped by a status read that returns it clear or by the clear itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_clear_armed <= 1'b0;
    end else if (rd_fire && rd_off == PPSIO_OFF_PIO_CTRL) begin
      flag_clear_armed <= strobe_in_flag;
    end else if (rd_fire && rd_off == PPSIO_OFF_LATCH_C) begin
      flag_clear_armed <= 1'b0;
    end
  end

  // interrupt request, one cycle behind the flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_in_irq <= 1'b0;
    end else begin
      strobe_in_irq <= strobe_in_flag && strobe_in_irq_enable;
    end
  end

  // strobe output timer: each port b write in simple strobed mode restarts a fresh pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_cnt <= 2'h0;
    end else if (wr_en && wr_off == PPSIO_OFF_PORT_B && strobed_mode) begin
      strobe_cnt <= 2'(PPSIO_STROBE_OUT_CYCLES);
    end else if (strobe_cnt != 2'h0) begin
      strobe_cnt <= strobe_cnt - 2'h1;
    end
  end

  // strobe output pin, standing in for the read/write pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_out_line <= !PPSIO_RST_INVERT;
    end else if (wr_en && wr_off == PPSIO_OFF_PORT_B && strobed_mode) begin
      strobe_out_line <= strobe_out_invert;
    end else if (strobe_cnt > 2'h1) begin
      strobe_out_line <= strobe_out_invert;
    end else begin
      strobe_out_line <= !strobe_out_invert;
    end
  end

  // pin drivers: registered so the pins change one cycle after the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_port_out <= PPSIO_RST_PORT;
      first_port_oe <= PPSIO_RST_DIR;
      second_port_out <= PPSIO_RST_PORT;
      third_port_out <= PPSIO_RST_PORT;
      third_port_oe <= PPSIO_RST_DIR;
      fourth_port_out <= PPSIO_RST_PORT;
      fourth_port_oe <= PPSIO_RST_DIR;
    end else begin
      first_port_out <= port_a_latch;
      first_port_oe <= PPSIO_PA_OUT_MASK |
                       {first_port_line7_dir, 7'h00};
      second_port_out <= port_b_latch;
      third_port_out <= port_c_latch;
      third_port_oe <= port_c_dir;
      fourth_port_out <= port_d_latch;
      fourth_port_oe <= port_d_dir;
    end
  end

  // per line read views: outputs show the driver input, inputs the pin
  for (genvar i = 0; i < PORT_W; i++) begin : g_view
    assign pins_c_view[i] = port_c_dir[i] ? port_c_latch[i]
                                          : third_port_in[i];
    assign pins_d_view[i] = port_d_dir[i] ? port_d_latch[i]
                                          : fourth_port_in[i];
  end

  // port a: 0..2 pins, 3..6 driver inputs, 7 by its direction
  assign port_a_view = {first_port_line7_dir ? port_a_latch[7]
                                             : first_port_in[7],
                        port_a_latch[6:3], first_port_in[2:0]};

  // control register as software sees it
  assign pio_ctrl_view = {strobe_in_flag, strobe_in_irq_enable, 1'b0,
                          handshake_select, 2'h0, strobe_in_edge_select,
                          strobe_out_invert};

  // read mux
  always_comb begin
    rd_hit = 1'b1;
    case (rd_off)
      PPSIO_OFF_PORT_A: rd_byte = port_a_view;
      PPSIO_OFF_PORT_B: rd_byte = port_b_latch;
      PPSIO_OFF_PINS_C: rd_byte = pins_c_view;
      PPSIO_OFF_LATCH_C: rd_byte = third_port_latched_reg;
      PPSIO_OFF_DIR_C: rd_byte = port_c_dir;
      PPSIO_OFF_PORT_D: rd_byte = pins_d_view;
      PPSIO_OFF_DIR_D: rd_byte = port_d_dir;
      PPSIO_OFF_PORT_E: rd_byte = fifth_port_in;
      PPSIO_OFF_PIO_CTRL: rd_byte = pio_ctrl_view;
      PPSIO_OFF_PACC_CTRL: rd_byte = {first_port_line7_dir, 7'h00};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read address channel: one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // read data channel: value sampled at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PPSIO_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? PPSIO_RESP_OKAY : PPSIO_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== shared/ppsio_pkg.sv
// package of offsets, field positions and reset values for the parallel port
package ppsio_pkg;

  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] PPSIO_OFF_PORT_A = 8'h00;
  localparam logic [7:0] PPSIO_OFF_PORT_B = 8'h04;
  localparam logic [7:0] PPSIO_OFF_PINS_C = 8'h08;
  localparam logic [7:0] PPSIO_OFF_LATCH_C = 8'h0C;
  localparam logic [7:0] PPSIO_OFF_DIR_C = 8'h10;
  localparam logic [7:0] PPSIO_OFF_PORT_D = 8'h14;
  localparam logic [7:0] PPSIO_OFF_DIR_D = 8'h18;
  localparam logic [7:0] PPSIO_OFF_PORT_E = 8'h1C;
  localparam logic [7:0] PPSIO_OFF_PIO_CTRL = 8'h20;
  localparam logic [7:0] PPSIO_OFF_PACC_CTRL = 8'h24;

  // parallel_io_control field positions
  localparam int PPSIO_BIT_FLAG = 7;
  localparam int PPSIO_BIT_IRQ_EN = 6;
  localparam int PPSIO_BIT_HANDSHAKE = 4;
  localparam int PPSIO_BIT_EDGE_SEL = 1;
  localparam int PPSIO_BIT_INVERT = 0;

  // pulse accumulator control: direction of port a line 7
  localparam int PPSIO_BIT_LINE7_DIR = 7;

  // values after reset
  localparam logic [7:0] PPSIO_RST_PORT = 8'h00;
  localparam logic [7:0] PPSIO_RST_DIR = 8'h00;
  localparam logic PPSIO_RST_EDGE_SEL = 1'b1;
  localparam logic PPSIO_RST_INVERT = 1'b1;

  // port a fixed line map: lines 3..6 always drive, 0..2 never
  localparam logic [7:0] PPSIO_PA_OUT_MASK = 8'h78;
  localparam logic [7:0] PPSIO_PA_WR_MASK = 8'hF8;

  // strobe output pulse length in clock (e clock) periods
  localparam int PPSIO_STROBE_OUT_CYCLES = 2;

  // axi response codes
  localparam logic [1:0] PPSIO_RESP_OKAY = 2'h0;
  localparam logic [1:0] PPSIO_RESP_SLVERR = 2'h2;

endpackage

// ===== tb/ppsio_partner.sv
// far-side device model: presents port c data, then strobes it in
`timescale 1ns/1ps
module ppsio_partner (
  // clock
  input wire logic aclk,
  // frame request from the bench
  input wire logic go,
  input wire logic rising,
  input wire logic [7:0] data,
  // lines toward the block
  output logic [7:0] pins,
  output logic strobe
);
  // frame step, zero between frames
  logic [2:0] step = 3'h0;
  initial begin
    pins = 8'h00;
    strobe = 1'b0;
  end
  // data stands three cycles before the edge and two after it
  always @(posedge aclk) begin
    if (step == 3'h0) begin
      strobe <= !rising; // inactive level between frames
      if (go) begin
        pins <= data;
        step <= 3'h1;
      end
    end else begin
      step <= step + 3'h1;
      if (step == 3'h3) strobe <= rising; // active edge, data settled
      if (step == 3'h5) begin
        strobe <= !rising;
        pins <= ~pins; // released: stale data must not look valid
        step <= 3'h0;
      end
    end
  end
endmodule

// ===== tb/ppsio_properties.sv
// checker of bus handshakes and pin timing for the parallel port block
`timescale 1ns/1ps
module ppsio_properties #(
  parameter int PORT_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic [PORT_W-1:0] first_port_out,
  input wire logic [PORT_W-1:0] first_port_oe,
  input wire logic strobe_out_line
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a strobe level change never lasts only one cycle
  property p_strobe_width;
    $changed(strobe_out_line) |=> $stable(strobe_out_line);
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("strobe output level held one cycle only");

  // low lines of port a never drive and never carry data
  property p_pa_low;
    first_port_oe[2:0] == 3'h0 && first_port_out[2:0] == 3'h0;
  endproperty
  a_pa_low: assert property (p_pa_low)
    else $error("port a low lines driven");

  // middle lines of port a always drive
  property p_pa_drive;
    $past(aresetn) |-> first_port_oe[6:3] == 4'hF;
  endproperty
  a_pa_drive: assert property (p_pa_drive)
    else $error("port a middle lines not driven");

  // write response holds until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");

  // read data holds until taken
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");

  // no write taken while a response is pending
  property p_aw_refused;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_refused: assert property (p_aw_refused)
    else $error("write taken during pending response");

  // registers are one byte wide
  property p_rdata_zero;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_rdata_zero: assert property (p_rdata_zero)
    else $error("upper read data bits not zero");

  // read answer one cycle after the address is taken
  property p_r_time;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_time: assert property (p_r_time)
    else $error("read answer late");

  // write answer soon after both halves taken
  property p_b_time;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_time: assert property (p_b_time)
    else $error("write answer late");
endmodule

// ===== tb/testbench.sv
// self-checking bench for the parallel port block
`timescale 1ns/1ps
module testbench import ppsio_pkg::*;;
  // clock, reset and bus
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  // pins; a, d and e inputs held fixed
  logic [7:0] first_port_in = 8'h05;
  logic [7:0] fourth_port_in = 8'h0F;
  logic [7:0] fifth_port_in = 8'hC3;
  logic [7:0] first_port_out, first_port_oe, second_port_out;
  logic [7:0] third_port_in, third_port_out, third_port_oe, far_pins;
  logic [7:0] fourth_port_out, fourth_port_oe;
  logic strobe_in_line, strobe_out_line, strobe_in_irq;
  // partner control
  logic go = 1'b0, rising = 1'b1;
  logic [7:0] pdata = 8'h00;
  // bench state
  int err_total = 0, tests_run = 0, pulse_cnt = 0;
  logic pulse_lvl = 1'b1;
  logic [31:0] rd_val;
  logic [1:0] resp;
  // rows: address, write data, value read back
  localparam logic [23:0] ROWS [7] = '{24'h00FF7D, 24'h04A5A5,
    24'h10F0F0, 24'h083C30, 24'h145A0F, 24'h1C12C3, 24'h289900};

  ppsio_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .first_port_in, .first_port_out, .first_port_oe,
    .second_port_out, .third_port_in, .third_port_out, .third_port_oe,
    .fourth_port_in, .fourth_port_out, .fourth_port_oe, .fifth_port_in,
    .strobe_in_line, .strobe_out_line, .strobe_in_irq);
  ppsio_partner i_far (.aclk, .go, .rising, .data(pdata),
    .pins(far_pins), .strobe(strobe_in_line));
  // port c wire: block where driving, else partner
  assign third_port_in = (third_port_oe & third_port_out) |
    (~third_port_oe & far_pins);

  always #20 aclk = ~aclk;
  // cycles at the strobe output's active level
  always @(posedge aclk) if (strobe_out_line === pulse_lvl) pulse_cnt++;

  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_val = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // one partner frame plus settle time
  task automatic send(input logic [7:0] d);
    @(posedge aclk);
    pdata <= d;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge aclk);
    chk("oe c in reset", third_port_oe, 8'h00);
    aresetn <= 1'b1;
    rd(PPSIO_OFF_PIO_CTRL);
    chk("ctrl reset", rd_val, 32'h03);
    rd(PPSIO_OFF_DIR_C);
    chk("dir c reset", rd_val, 32'h00);
    rd(PPSIO_OFF_DIR_D);
    chk("dir d reset", rd_val, 32'h00);
    $display("test reset done");
    foreach (ROWS[i]) begin
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      chk("wr resp", resp, (ROWS[i][23:16] == 8'h28) ?
        PPSIO_RESP_SLVERR : PPSIO_RESP_OKAY);
      rd(ROWS[i][23:16]);
      chk("row read", rd_val, {24'h0, ROWS[i][7:0]});
      chk("row resp", {30'h0, resp}, {30'h0, (ROWS[i][23:16] == 8'h28) ?
        PPSIO_RESP_SLVERR : PPSIO_RESP_OKAY});
    end
    chk("port a out", first_port_out, 8'hF8);
    chk("port a oe", first_port_oe, 8'h78);
    chk("port b out", second_port_out, 8'hA5);
    chk("port c out", third_port_out, 8'h3C);
    chk("port c oe", third_port_oe, 8'hF0);
    $display("test rows done");
    wr(PPSIO_OFF_PACC_CTRL, 8'h80);
    repeat (2) @(posedge aclk);
    chk("line7 oe", first_port_oe, 8'hF8);
    rd(PPSIO_OFF_PORT_A);
    chk("line7 read", rd_val, 32'hFD);
    wr(PPSIO_OFF_DIR_D, 8'hFF);
    repeat (2) @(posedge aclk);
    chk("port d out", fourth_port_out, 8'h5A);
    chk("port d oe", fourth_port_oe, 8'hFF);
    rd(PPSIO_OFF_PORT_D);
    chk("port d read", rd_val, 32'h5A);
    $display("test directions done");
    pulse_cnt = 0;
    wr(PPSIO_OFF_PORT_B, 8'h3C);
    repeat (4) @(posedge aclk);
    chk("pulse high", pulse_cnt, 32'd2);
    wr(PPSIO_OFF_PIO_CTRL, 8'h02);
    repeat (3) @(posedge aclk);
    chk("idle high", strobe_out_line, 1'b1);
    pulse_lvl = 1'b0;
    pulse_cnt = 0;
    wr(PPSIO_OFF_PORT_B, 8'h3D);
    repeat (4) @(posedge aclk);
    chk("pulse low", pulse_cnt, 32'd2);
    $display("test strobe out done");
    wr(PPSIO_OFF_PIO_CTRL, 8'h43);
    send(8'hA6);
    chk("irq set", strobe_in_irq, 1'b1);
    rd(PPSIO_OFF_PIO_CTRL);
    chk("flag set", rd_val, 32'hC3);
    rd(PPSIO_OFF_LATCH_C);
    chk("latched", rd_val, 32'h36);
    rd(PPSIO_OFF_PIO_CTRL);
    chk("flag clear", rd_val, 32'h43);
    repeat (2) @(posedge aclk);
    chk("irq clear", strobe_in_irq, 1'b0);
    send(8'h11);
    send(8'h22);
    rd(PPSIO_OFF_LATCH_C);
    chk("overwrite", rd_val, 32'h32);
    rd(PPSIO_OFF_PIO_CTRL);
    chk("flag kept", rd_val, 32'hC3);
    $display("test capture done");
    wr(PPSIO_OFF_PIO_CTRL, 8'h41);
    rising <= 1'b0;
    send(8'h5C);
    rd(PPSIO_OFF_LATCH_C);
    chk("falling edge", rd_val, 32'h3C);
    $display("test edge select done");
    wr(PPSIO_OFF_PIO_CTRL, 8'h11);
    pulse_lvl = 1'b1;
    pulse_cnt = 0;
    wr(PPSIO_OFF_PORT_B, 8'h55);
    repeat (4) @(posedge aclk);
    chk("no pulse", pulse_cnt, 32'd0);
    send(8'h77);
    rd(PPSIO_OFF_LATCH_C);
    chk("no capture", rd_val, 32'h3C);
    $display("test handshake done");
    tally_and_finish();
  end
endmodule

bind ppsio_top ppsio_properties #(.PORT_W(PORT_W)) i_props (.aclk,
  .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .first_port_out, .first_port_oe, .strobe_out_line);
